// *** logic/scr_pkg.sv ***
package scr_pkg;

    // Register byte offsets
    localparam logic [11:0] SCR_OFS_PERIPH_RST = 12'h00C;
    localparam logic [11:0] SCR_OFS_BOD = 12'h018;
    localparam logic [11:0] SCR_OFS_TEMP = 12'h01C;
    localparam logic [11:0] SCR_OFS_POR = 12'h024;
    localparam logic [11:0] SCR_OFS_PORTA = 12'h030;

    // Reset values
    localparam logic [31:0] SCR_RST_PERIPH = 32'h0000_0000;
    localparam logic [31:0] SCR_RST_PORTA = 32'h0000_0000;
    localparam logic [15:0] SCR_RST_POR_CODE = 16'h0000;
    localparam logic SCR_RST_TEMP_EN = 1'b0;
    localparam logic SCR_RST_LOW_VOLTAGE_RESET_ENABLE = 1'b1;
    localparam logic SCR_RST_BROWNOUT_LOW_POWER_SELECT = 1'b0;

    // Writable bits of the reset-hold register
    localparam logic [31:0] SCR_PERIPH_MASK = 32'h0077_F33E;

    // Brown-out control field positions
    localparam int SCR_BROWNOUT_DETECTOR_ENABLE_POS = 0;
    localparam int SCR_BROWNOUT_THRESHOLD_SELECT_LSB = 1;
    localparam int SCR_BROWNOUT_RESET_SELECT_POS = 3;
    localparam int SCR_BROWNOUT_INTERRUPT_FLAG_POS = 4;
    localparam int SCR_BROWNOUT_LOW_POWER_SELECT_POS = 5;
    localparam int SCR_BROWNOUT_OUTPUT_STATUS_POS = 6;
    localparam int SCR_LOW_VOLTAGE_RESET_ENABLE_POS = 7;

    // Flash user configuration word positions
    localparam int SCR_CFG_RSTEN_POS = 20;
    localparam int SCR_CFG_VL_LSB = 21;
    localparam int SCR_CFG_EN_POS = 23;

    // Power-on-reset disable code
    localparam logic [15:0] SCR_POR_DIS_KEY = 16'h5AA5;

    // Detector settling time before low-voltage reset acts
    localparam int SCR_CLK_HZ = 25_000_000;
    localparam int SCR_LVR_SETTLE_US = 100;
    localparam int SCR_LVR_SETTLE_CYC = (SCR_LVR_SETTLE_US * (SCR_CLK_HZ / 1_000_000) > 0) ?
        SCR_LVR_SETTLE_US * (SCR_CLK_HZ / 1_000_000) : 1;

    typedef enum logic [1:0] {
        SCR_VL_2V2 = 2'b00,
        SCR_VL_2V7 = 2'b01,
        SCR_VL_3V8 = 2'b10,
        SCR_VL_4V5 = 2'b11
    } scr_vl_t;

    typedef enum logic [2:0] {
        SCR_PF_GPIO = 3'b000,
        SCR_PF_PULSE = 3'b001,
        SCR_PF_AUDIO_CLK = 3'b010,
        SCR_PF_EBUS_AD = 3'b011,
        SCR_PF_TWI_CLK = 3'b100,
        SCR_PF_TWI_DATA = 3'b101,
        SCR_PF_EBUS_RD = 3'b110,
        SCR_PF_EBUS_WR = 3'b111
    } scr_pin_func_t;

    // Brown-out side effects as one bundle
    typedef struct packed {
        logic detector_enable;
        scr_vl_t threshold;
        logic low_power;
        logic chip_reset_req;
        logic irq;
        logic lvr_active;
    } scr_brownout_output_status_t;

    // Alternate-function bits used by the port A decode
    typedef struct packed {
        logic audio_clock_select;
        logic external_bus_enable;
        logic [7:5] external_bus_high_byte_enable;
    } scr_alt_t;

endpackage

// *** logic/scr_bank.sv ***
// Behaviour
// - Serial and synchronous-serial reset bits hold their controller in reset while one.
// - Comparator, pulse, two-wire, timer and port reset bits at fixed positions.
// - Low-voltage-reset enable resets to one and is protected.
// - Low-voltage reset acts only after 100 us settling following enable.
// - Brown-out status reads supply-below, and zero while detector disabled.
// - Status change sets the brown-out flag; writing one clears it.
// - Enabled detector with reset select resets chip while status high.
// - Enabled detector without reset select raises interrupt while status high.
// - Threshold and enable preload from flash configuration bits 22:21 and 23.
// - Protected low-power bit, one low-power, zero normal by default.
// - Temperature sensor enable resets to zero and enables the sensor.
// - Power-on reset is disabled while disable code holds 0x5AA5.
// - Any other code, or another reset source, re-enables power-on reset.
// - Port A upper sixteen bits enable Schmitt inputs per pin.
// - A15 selects GPIO, pulse output three, or audio master clock.
// - A14..A12 select GPIO, pulse outputs, or external-bus address/data bits.
// - A9 selects first two-wire clock when its bit is one.
`timescale 1ns/100ps
module scr_bank
    import scr_pkg::*;
#(
    parameter int LVR_SETTLE_CYC = SCR_LVR_SETTLE_CYC
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // System inputs
    input wire logic write_protect_open,
    input wire logic [31:0] flash_user_config_word,
    input wire logic supply_below_threshold,
    input wire logic other_reset_event,
    input wire scr_alt_t alt_bits,
    // Controls out
    output logic [31:0] peripheral_reset_hold,
    output scr_brownout_output_status_t bod_ctrl,
    output logic temp_sensor_enable,
    output logic power_on_reset_disable,
    output logic [15:0] port_a_schmitt_enable,
    output scr_pin_func_t [15:9] port_a_pin_func
);

    logic [31:0] periph_reg;
    logic [31:0] porta_reg;
    logic [15:0] por_code_reg;
    logic temp_en_reg;
    logic low_voltage_reset_enable_reg;
    logic brownout_low_power_select_reg;
    logic brownout_reset_select_reg;
    logic [1:0] brownout_threshold_select_reg;
    logic brownout_detector_enable_reg;
    logic brownout_output_status_reg;
    logic brownout_interrupt_flag_reg;
    logic cfg_loaded_reg;
    logic [15:0] lvr_cnt_reg;
    logic [31:0] prdata_reg;
    logic pready_reg;
    logic pslverr_reg;
    logic wr_en;
    logic rd_setup;
    logic brownout_output_status_next;

    function automatic logic addr_known(input logic [11:0] a);
        return a == SCR_OFS_PERIPH_RST || a == SCR_OFS_BOD || a == SCR_OFS_TEMP ||
            a == SCR_OFS_POR || a == SCR_OFS_PORTA;
    endfunction

    function automatic logic wr_hit(input logic [11:0] ofs);
        return wr_en && paddr == ofs;
    endfunction

    // Port A pin decode; anything not listed falls back to GPIO
    function automatic scr_pin_func_t pin_func(input int pin, input logic sel, input scr_alt_t alt);
        scr_pin_func_t f;
        f = SCR_PF_GPIO;
        if (sel) begin
            case (pin)
                15: f = alt.audio_clock_select ? SCR_PF_AUDIO_CLK : SCR_PF_PULSE;
                14, 13, 12: begin
                    if (!alt.external_bus_enable && !alt.external_bus_high_byte_enable[pin - 7]) begin
                        f = SCR_PF_PULSE;
                    end else if (alt.external_bus_enable &&
                                 alt.external_bus_high_byte_enable[pin - 7]) begin
                        f = SCR_PF_EBUS_AD;
                    end
                end
                11: f = alt.external_bus_enable ? SCR_PF_EBUS_RD : SCR_PF_TWI_CLK;
                10: f = alt.external_bus_enable ? SCR_PF_EBUS_WR : SCR_PF_TWI_DATA;
                9: f = SCR_PF_TWI_CLK;
                default: f = SCR_PF_GPIO;
            endcase
        end
        return f;
    endfunction

    // Write lands in the access phase; read data is prepared in setup
    assign wr_en = psel && penable && pready_reg && pwrite;
    assign rd_setup = psel && !penable;
    assign brownout_output_status_next = brownout_detector_enable_reg && supply_below_threshold;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
        end else begin
            pready_reg <= rd_setup;
            pslverr_reg <= rd_setup && !addr_known(paddr);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= 32'h0000_0000;
        end else if (rd_setup && !pwrite) begin
            case (paddr)
                SCR_OFS_PERIPH_RST: prdata_reg <= periph_reg;
                SCR_OFS_BOD: prdata_reg <= {24'h00_0000, low_voltage_reset_enable_reg, brownout_output_status_reg, brownout_low_power_select_reg,
                                            brownout_interrupt_flag_reg, brownout_reset_select_reg, brownout_threshold_select_reg, brownout_detector_enable_reg};
                SCR_OFS_TEMP: prdata_reg <= {31'h0000_0000, temp_en_reg};
                SCR_OFS_POR: prdata_reg <= {16'h0000, por_code_reg};
                SCR_OFS_PORTA: prdata_reg <= porta_reg;
                default: prdata_reg <= 32'h0000_0000;
            endcase
        end else begin
            prdata_reg <= 32'h0000_0000;
        end
    end

    // Reset-hold bits change only by software writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            periph_reg <= SCR_RST_PERIPH;
        end else if (wr_hit(SCR_OFS_PERIPH_RST)) begin
            periph_reg <= pwdata & SCR_PERIPH_MASK;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            porta_reg <= SCR_RST_PORTA;
            temp_en_reg <= SCR_RST_TEMP_EN;
        end else begin
            if (wr_hit(SCR_OFS_PORTA)) begin
                porta_reg <= pwdata;
            end
            if (wr_hit(SCR_OFS_TEMP)) begin
                temp_en_reg <= pwdata[0];
            end
        end
    end

    // Other reset sources put the code back so power-on reset returns
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            por_code_reg <= SCR_RST_POR_CODE;
        end else if (other_reset_event) begin
            por_code_reg <= SCR_RST_POR_CODE;
        end else if (wr_hit(SCR_OFS_POR) && write_protect_open) begin
            por_code_reg <= pwdata[15:0];
        end
    end

    // Flash preload one edge after release; a reset cannot sample a port
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_loaded_reg <= 1'b0;
            brownout_reset_select_reg <= 1'b0;
            brownout_threshold_select_reg <= 2'b00;
            brownout_detector_enable_reg <= 1'b0;
            brownout_low_power_select_reg <= SCR_RST_BROWNOUT_LOW_POWER_SELECT;
            low_voltage_reset_enable_reg <= SCR_RST_LOW_VOLTAGE_RESET_ENABLE;
        end else if (!cfg_loaded_reg) begin
            cfg_loaded_reg <= 1'b1;
            brownout_reset_select_reg <= flash_user_config_word[SCR_CFG_RSTEN_POS];
            brownout_threshold_select_reg <= flash_user_config_word[SCR_CFG_VL_LSB +: 2];
            brownout_detector_enable_reg <= flash_user_config_word[SCR_CFG_EN_POS];
        end else if (wr_hit(SCR_OFS_BOD) && write_protect_open) begin
            low_voltage_reset_enable_reg <= pwdata[SCR_LOW_VOLTAGE_RESET_ENABLE_POS];
            brownout_low_power_select_reg <= pwdata[SCR_BROWNOUT_LOW_POWER_SELECT_POS];
            brownout_reset_select_reg <= pwdata[SCR_BROWNOUT_RESET_SELECT_POS];
            brownout_threshold_select_reg <= pwdata[SCR_BROWNOUT_THRESHOLD_SELECT_LSB +: 2];
            brownout_detector_enable_reg <= pwdata[SCR_BROWNOUT_DETECTOR_ENABLE_POS];
        end
    end

    // Status is forced low while the detector is off
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            brownout_output_status_reg <= 1'b0;
        end else begin
            brownout_output_status_reg <= brownout_output_status_next;
        end
    end

    // Set wins over a simultaneous write-one clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            brownout_interrupt_flag_reg <= 1'b0;
        end else if (brownout_output_status_next != brownout_output_status_reg) begin
            brownout_interrupt_flag_reg <= 1'b1;
        end else if (wr_hit(SCR_OFS_BOD) && pwdata[SCR_BROWNOUT_INTERRUPT_FLAG_POS]) begin
            brownout_interrupt_flag_reg <= 1'b0;
        end
    end

    // Settling counter restarts whenever the enable drops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lvr_cnt_reg <= 16'h0000;
        end else if (!low_voltage_reset_enable_reg) begin
            lvr_cnt_reg <= 16'h0000;
        end else if (lvr_cnt_reg < 16'(LVR_SETTLE_CYC)) begin
            lvr_cnt_reg <= lvr_cnt_reg + 16'h0001;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bod_ctrl <= '0;
        end else begin
            bod_ctrl.detector_enable <= brownout_detector_enable_reg;
            bod_ctrl.threshold <= scr_vl_t'(brownout_threshold_select_reg);
            bod_ctrl.low_power <= brownout_low_power_select_reg;
            bod_ctrl.chip_reset_req <= brownout_detector_enable_reg && brownout_reset_select_reg && brownout_output_status_reg;
            bod_ctrl.irq <= brownout_detector_enable_reg && !brownout_reset_select_reg &&
                (brownout_output_status_reg || brownout_interrupt_flag_reg);
            bod_ctrl.lvr_active <= low_voltage_reset_enable_reg && lvr_cnt_reg >= 16'(LVR_SETTLE_CYC);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            peripheral_reset_hold <= 32'h0000_0000;
            temp_sensor_enable <= 1'b0;
            power_on_reset_disable <= 1'b0;
            port_a_schmitt_enable <= 16'h0000;
        end else begin
            peripheral_reset_hold <= periph_reg;
            temp_sensor_enable <= temp_en_reg;
            power_on_reset_disable <= por_code_reg == SCR_POR_DIS_KEY;
            port_a_schmitt_enable <= porta_reg[31:16];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_a_pin_func <= '{default: SCR_PF_GPIO};
        end else begin
            for (int p = 9; p <= 15; p++) begin
                port_a_pin_func[p] <= pin_func(p, porta_reg[p], alt_bits);
            end
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;

    AST_LVR_RESET_ONE: assert property (@(posedge pclk) $rose(presetn) |-> low_voltage_reset_enable_reg)
        else $error("low-voltage enable not one after reset");

    AST_LVR_SETTLE: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(low_voltage_reset_enable_reg) |-> !bod_ctrl.lvr_active [*8])
        else $error("low-voltage reset active before settling");

    AST_LVR_ACTIVE_ENDS: assert property (@(posedge pclk) disable iff (!presetn)
        !low_voltage_reset_enable_reg |=> !bod_ctrl.lvr_active)
        else $error("low-voltage reset active while disabled");

    AST_BROWNOUT_OUTPUT_STATUS_OFF: assert property (@(posedge pclk) disable iff (!presetn)
        !brownout_detector_enable_reg |=> !brownout_output_status_reg)
        else $error("brown-out status high with detector off");

    AST_INTF_SET: assert property (@(posedge pclk) disable iff (!presetn)
        brownout_output_status_next != brownout_output_status_reg |=> brownout_interrupt_flag_reg)
        else $error("brown-out flag not set on crossing");

    AST_INTF_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
        wr_hit(SCR_OFS_BOD) && pwdata[SCR_BROWNOUT_INTERRUPT_FLAG_POS] && brownout_output_status_next == brownout_output_status_reg
        |=> !brownout_interrupt_flag_reg)
        else $error("brown-out flag not cleared by write one");

    AST_BOD_RESET: assert property (@(posedge pclk) disable iff (!presetn)
        brownout_detector_enable_reg && brownout_reset_select_reg && brownout_output_status_reg |=> bod_ctrl.chip_reset_req &&
        !bod_ctrl.irq)
        else $error("brown-out reset not requested");

    AST_BOD_IRQ: assert property (@(posedge pclk) disable iff (!presetn)
        bod_ctrl.irq |-> $past(brownout_detector_enable_reg) && !$past(brownout_reset_select_reg))
        else $error("brown-out interrupt without enable");

    AST_POR_KEY: assert property (@(posedge pclk) disable iff (!presetn)
        power_on_reset_disable |-> $past(por_code_reg) == SCR_POR_DIS_KEY)
        else $error("power-on reset disabled without key");

    AST_LOCKED_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
        wr_hit(SCR_OFS_POR) && !write_protect_open && !other_reset_event
        |=> $stable(por_code_reg))
        else $error("protected field changed while locked");

    AST_PERIPH_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
        !wr_hit(SCR_OFS_PERIPH_RST) |=> $stable(periph_reg))
        else $error("reset-hold bits changed without a write");

    AST_PERIPH_OUT: assert property (@(posedge pclk) disable iff (!presetn)
        wr_hit(SCR_OFS_PERIPH_RST) |=> ##1
        peripheral_reset_hold == ($past(pwdata, 2) & SCR_PERIPH_MASK))
        else $error("reset-hold output mismatch");

    AST_A9_FUNC: assert property (@(posedge pclk) disable iff (!presetn)
        ##1 port_a_pin_func[9] == ($past(porta_reg[9]) ? SCR_PF_TWI_CLK : SCR_PF_GPIO))
        else $error("pin A9 function wrong");

    AST_A15_FUNC: assert property (@(posedge pclk) disable iff (!presetn)
        porta_reg[15] && alt_bits.audio_clock_select |=>
        port_a_pin_func[15] == SCR_PF_AUDIO_CLK)
        else $error("pin A15 audio clock not selected");

    AST_APB_ANSWER: assert property (@(posedge pclk) disable iff (!presetn)
        psel && !penable |=> pready)
        else $error("no answer in access phase");

    COV_INTF_SET: cover property (@(posedge pclk) disable iff (!presetn) $rose(brownout_interrupt_flag_reg));
    COV_BOD_RESET: cover property (@(posedge pclk) disable iff (!presetn)
        $rose(bod_ctrl.chip_reset_req));
    COV_POR_DIS: cover property (@(posedge pclk) disable iff (!presetn)
        $rose(power_on_reset_disable));
    COV_LVR_ACTIVE: cover property (@(posedge pclk) disable iff (!presetn)
        $rose(bod_ctrl.lvr_active));

endmodule

// *** dv/tb_scr_bank.sv ***
`timescale 1ns/100ps
module tb_scr_bank
    import scr_pkg::*;
;
    typedef struct packed {
        logic [11:0] a;
        logic [31:0] d;
        logic [31:0] e;
        logic err;
    } scr_tb_reg_t;
    typedef struct packed {
        logic [31:0] pa;
        scr_alt_t alt;
        logic [20:0] f;
    } scr_tb_pin_t;
    // Write then read back, protection open
    localparam scr_tb_reg_t REG_ROWS [7] = '{
        '{SCR_OFS_PERIPH_RST, 32'hFFFF_FFFF, SCR_PERIPH_MASK, 1'b0},
        '{SCR_OFS_PERIPH_RST, 32'h0005_1000, 32'h0005_1000, 1'b0},
        '{SCR_OFS_PERIPH_RST, 32'h0000_0000, 32'h0000_0000, 1'b0},
        '{SCR_OFS_TEMP, 32'hFFFF_FFFF, 32'h0000_0001, 1'b0},
        '{SCR_OFS_POR, 32'hFFFF_FFFF, 32'h0000_FFFF, 1'b0},
        '{SCR_OFS_PORTA, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 1'b0},
        '{12'h040, 32'hFFFF_FFFF, 32'h0000_0000, 1'b1}
    };
    // Pin A15 down to A9, three bits each
    localparam scr_tb_pin_t PIN_ROWS [5] = '{
        '{32'hA5A5_FE00, 5'h00, {3'h1, 3'h1, 3'h1, 3'h1, 3'h4, 3'h5, 3'h4}},
        '{32'h5A5A_FE00, 5'h1F, {3'h2, 3'h3, 3'h3, 3'h3, 3'h6, 3'h7, 3'h4}},
        '{32'h0001_FE00, 5'h08, {3'h1, 3'h0, 3'h0, 3'h0, 3'h6, 3'h7, 3'h4}},
        '{32'h8000_FE00, 5'h15, {3'h2, 3'h0, 3'h1, 3'h0, 3'h4, 3'h5, 3'h4}},
        '{32'h0000_0000, 5'h1F, {3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0}}
    };
    logic pclk = 1'b0;
    logic presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, flash_cfg, prh, r;
    logic wp_open, supply_below, other_rst, temp_en, por_dis, e;
    scr_alt_t alt;
    scr_brownout_output_status_t bod;
    logic [15:0] schmitt;
    scr_pin_func_t [15:9] pin_func;
    int mismatches = 0;
    int num_checks = 0;

    always #20 pclk = ~pclk;

    // Short settle count keeps the run brief
    scr_bank #(.LVR_SETTLE_CYC(10)) u_scr_bank (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .write_protect_open(wp_open),
        .flash_user_config_word(flash_cfg), .supply_below_threshold(supply_below),
        .other_reset_event(other_rst), .alt_bits(alt), .peripheral_reset_hold(prh),
        .bod_ctrl(bod), .temp_sensor_enable(temp_en), .power_on_reset_disable(por_dis),
        .port_a_schmitt_enable(schmitt), .port_a_pin_func(pin_func)
    );

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string m);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp, input string m);
        chk_word({31'h0, got}, {31'h0, exp}, m);
    endtask

    task automatic chk_func(input scr_pin_func_t got, input logic [2:0] exp);
        num_checks++;
        if (got !== scr_pin_func_t'(exp)) begin
            mismatches++;
            $display("wrong value at %0t: pin function %h exp %h", $time, got, exp);
        end
    endtask

    // One transfer; an idle cycle follows so no strobe is driven twice in a step
    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (n >= 16) begin
            mismatches++;
            $display("wrong value at %0t: no ready", $time);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] x;
        logic y;
        apb(a, 1'b1, d, x, y);
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] x;
        logic y;
        apb(a, 1'b0, 32'h0000_0000, x, y);
        chk_word(x, exp, "register read");
    endtask

    task automatic reset_dut(input logic [31:0] cfg, input logic [31:0] bod_exp);
        @(posedge pclk);
        presetn <= 1'b0;
        flash_cfg <= cfg;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        rd_chk(SCR_OFS_BOD, bod_exp);
        rd_chk(SCR_OFS_PERIPH_RST, SCR_RST_PERIPH);
        rd_chk(SCR_OFS_TEMP, {31'h0, SCR_RST_TEMP_EN});
        rd_chk(SCR_OFS_POR, {16'h0, SCR_RST_POR_CODE});
        rd_chk(SCR_OFS_PORTA, SCR_RST_PORTA);
        chk_bit(bod.detector_enable, cfg[SCR_CFG_EN_POS], "detector enable");
        chk_word({30'h0, bod.threshold}, {30'h0, cfg[22:21]}, "threshold");
        repeat (20) @(posedge pclk);
        chk_bit(bod.lvr_active, 1'b1, "lvr after reset");
    endtask

    initial begin
        repeat (20000) @(posedge pclk);
        mismatches++;
        $display("wrong value at %0t: watchdog expired", $time);
        report_and_stop();
    end

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        flash_cfg = 32'h0000_0000;
        wp_open = 1'b1;
        supply_below = 1'b0;
        other_rst = 1'b0;
        alt = 5'h00;
        reset_dut(32'h00C0_0000, 32'h0000_0085);
        foreach (REG_ROWS[i]) begin
            apb(REG_ROWS[i].a, 1'b1, REG_ROWS[i].d, r, e);
            chk_bit(e, REG_ROWS[i].err, "write error");
            apb(REG_ROWS[i].a, 1'b0, 32'h0000_0000, r, e);
            chk_word(r, REG_ROWS[i].e, "readback");
            chk_bit(e, REG_ROWS[i].err, "read error");
        end
        repeat (3) @(posedge pclk);
        chk_bit(temp_en, 1'b1, "temp enable");
        wr(SCR_OFS_PERIPH_RST, 32'h0005_1000);
        repeat (3) @(posedge pclk);
        chk_word(prh, 32'h0005_1000, "reset hold");
        wr(SCR_OFS_POR, {16'h0, SCR_POR_DIS_KEY});
        repeat (3) @(posedge pclk);
        chk_bit(por_dis, 1'b1, "por disabled");
        other_rst <= 1'b1;
        @(posedge pclk);
        other_rst <= 1'b0;
        repeat (3) @(posedge pclk);
        chk_bit(por_dis, 1'b0, "por after event");
        rd_chk(SCR_OFS_POR, 32'h0000_0000);
        wr(SCR_OFS_POR, {16'h0, SCR_POR_DIS_KEY});
        wr(SCR_OFS_POR, 32'h0000_5AA4);
        repeat (3) @(posedge pclk);
        chk_bit(por_dis, 1'b0, "por other code");
        // Mid-run reset with a different preload
        reset_dut(32'h0070_0000, 32'h0000_008E);
        wp_open <= 1'b0;
        wr(SCR_OFS_BOD, 32'h0000_0000);
        rd_chk(SCR_OFS_BOD, 32'h0000_008E);
        wr(SCR_OFS_POR, {16'h0, SCR_POR_DIS_KEY});
        rd_chk(SCR_OFS_POR, 32'h0000_0000);
        wr(SCR_OFS_PERIPH_RST, 32'h0000_0100);
        rd_chk(SCR_OFS_PERIPH_RST, 32'h0000_0100);
        wp_open <= 1'b1;
        wr(SCR_OFS_BOD, 32'h0000_0085);
        supply_below <= 1'b1;
        repeat (5) @(posedge pclk);
        rd_chk(SCR_OFS_BOD, 32'h0000_00D5);
        chk_bit(bod.irq, 1'b1, "irq mode");
        chk_bit(bod.chip_reset_req, 1'b0, "no reset in irq mode");
        // Flag clear is unprotected, so it works while locked
        wp_open <= 1'b0;
        wr(SCR_OFS_BOD, 32'h0000_0010);
        rd_chk(SCR_OFS_BOD, 32'h0000_00C5);
        chk_bit(bod.irq, 1'b1, "irq held");
        supply_below <= 1'b0;
        repeat (5) @(posedge pclk);
        rd_chk(SCR_OFS_BOD, 32'h0000_0095);
        wp_open <= 1'b1;
        wr(SCR_OFS_BOD, 32'h0000_0099);
        rd_chk(SCR_OFS_BOD, 32'h0000_0089);
        supply_below <= 1'b1;
        repeat (5) @(posedge pclk);
        chk_bit(bod.chip_reset_req, 1'b1, "chip reset");
        chk_bit(bod.irq, 1'b0, "no irq in reset mode");
        wr(SCR_OFS_BOD, 32'h0000_00B0);
        repeat (3) @(posedge pclk);
        apb(SCR_OFS_BOD, 1'b0, 32'h0000_0000, r, e);
        chk_word(r & 32'hFFFF_FFEF, 32'h0000_00A0, "disabled status");
        chk_bit(bod.irq, 1'b0, "irq blocked");
        chk_bit(bod.chip_reset_req, 1'b0, "reset blocked");
        chk_bit(bod.low_power, 1'b1, "low power");
        for (int i = 0; i < 4; i++) begin
            wr(SCR_OFS_BOD, 32'h0000_0080 | (32'(i) << 1));
            repeat (3) @(posedge pclk);
            chk_word({30'h0, bod.threshold}, 32'(i), "threshold code");
        end
        wr(SCR_OFS_BOD, 32'h0000_0000);
        repeat (3) @(posedge pclk);
        chk_bit(bod.lvr_active, 1'b0, "lvr off");
        wr(SCR_OFS_BOD, 32'h0000_0080);
        repeat (7) @(posedge pclk);
        chk_bit(bod.lvr_active, 1'b0, "lvr settling");
        repeat (5) @(posedge pclk);
        chk_bit(bod.lvr_active, 1'b1, "lvr settled");
        foreach (PIN_ROWS[i]) begin
            wr(SCR_OFS_PORTA, PIN_ROWS[i].pa);
            alt <= PIN_ROWS[i].alt;
            repeat (3) @(posedge pclk);
            chk_word({16'h0, schmitt}, {16'h0, PIN_ROWS[i].pa[31:16]}, "schmitt");
            for (int k = 0; k < 7; k++) begin
                chk_func(pin_func[15 - k], PIN_ROWS[i].f[20 - 3 * k -: 3]);
            end
        end
        report_and_stop();
    end
endmodule
